//--- pkg/tefb_consts.svh
/*
  Register offsets, field positions and reset values of the timer
  event flag bank. Assumes inclusion by bare name from design files.
*/
`ifndef TEFB_CONSTS_SVH
`define TEFB_CONSTS_SVH
// Register byte offsets
`define TEFB_OFS_FLAGS     12'h010
`define TEFB_OFS_MASK      12'h018
`define TEFB_OFS_CFG       12'h01C
`define TEFB_OFS_CHA_CV    12'h034
`define TEFB_OFS_MCHA_CV   12'h044
// Flag bit positions
`define TEFB_BIT_UPD       0
`define TEFB_BIT_CH0       1
`define TEFB_BIT_CMT       5
`define TEFB_BIT_TRG       6
`define TEFB_BIT_BRK       7
`define TEFB_BIT_OF0       9
`define TEFB_BIT_MCH0      20
// Implemented flag bits
`define TEFB_FLAG_MASK     32'h0010_1EFF
// Reset values
`define TEFB_RST_FLAGS     32'h0000_0000
`define TEFB_RST_MASK      32'h0000_0000
`define TEFB_RST_CFG       32'h0000_0000
// Config bit positions
`define TEFB_CFG_PAUSE     0
`define TEFB_CFG_TRGPOL    1
`define TEFB_CFG_INMODE    4
`define TEFB_CFG_MINMODE   8
`endif

//--- pkg/tefb_pkg.sv
/*
  Types of the timer event flag bank.
  Assumes the consts header for numbers.
*/
package tefb_pkg;
  // Events from the timer core, one-cycle pulses except the break and trigger levels
  typedef struct packed {
    logic [3:0] chan_capture;   // Capture event per channel
    logic [3:0] chan_compare;   // Compare match per channel
    logic       mchan_capture;  // Multi-mode channel a capture
    logic       mchan_compare;  // Multi-mode channel a compare
    logic       commutation;    // Commutation event
    logic       update;         // Update event
    logic       brk_level;      // Break input active level
    logic       trig_in;        // Raw trigger input level
  } tefb_events_t;
endpackage

//--- rtl/tefb_flag_bank.sv
/*
  Timer event flag bank: sticky event flags with APB access,
  interrupt mask and one interrupt output.
  Assumes event pulses from the timer core, synchronous to pclk.
*/
// Notes on behaviour
// - Capture on set chan a flag sets overcapture
// - Channels b-d overcapture flags behave alike
// - Break sets flag; clear only when inactive
// - Trigger event sets sticky trigger flag
// - Pause mode: both trigger edges count
// - Commutation event sets sticky flag
// - Chan a flag on capture or compare
// - Reading chan a capture value in input mode clears flag
// - Channels b-d event flags set alike; only a software write clears them
// - Update event sets sticky update flag
// - Multi chan flag reads one after event
// - Multi capture value read in input mode clears its flag
`timescale 1ns/100ps
`include "tefb_consts.svh"
module tefb_flag_bank
(
  input  wire logic                 pclk,      // APB clock
  input  wire logic                 presetn,   // Async reset, low
  input  wire logic                 psel,      // APB select
  input  wire logic                 penable,   // APB enable
  input  wire logic                 pwrite,    // APB direction
  input  wire logic [11:0]          paddr,     // APB byte address
  input  wire logic [31:0]          pwdata,    // APB write data
  input  wire logic [3:0]           pstrb,     // APB byte strobes
  input  wire tefb_pkg::tefb_events_t events,  // Timer core events
  input  wire logic [31:0]          cha_cv,    // Chan a capture value
  input  wire logic [31:0]          mcha_cv,   // Multi chan a capture value
  output logic [31:0]               prdata,    // APB read data
  output logic                      pready,    // APB ready
  output logic                      pslverr,   // APB error
  output logic                      irq        // Interrupt, high level
);
  import tefb_pkg::*;

  logic [31:0] flags_q;   // Event flags
  logic [31:0] flags_d;   // Next flags
  logic [31:0] mask_q;    // Interrupt mask
  logic [31:0] cfg_q;     // Mode configuration
  logic [31:0] set_v;     // Hardware set terms
  logic [31:0] clr_v;     // Software clear terms
  logic [3:0]  cap_ev;    // Capture events gated by input mode
  logic [3:0]  cmp_ev;    // Compare events gated by output mode
  logic        trig_ev;   // Trigger event pulse
  logic        m_cap;     // Multi chan capture in input mode
  logic        acc;       // Access phase
  logic        wr_ok;     // Full word write
  logic        rd_acc;    // Read access
  logic        bad;       // Unmapped or partial write

  // Address decode, used for both read and write
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `TEFB_OFS_FLAGS) || (a == `TEFB_OFS_MASK) ||
             (a == `TEFB_OFS_CFG) || (a == `TEFB_OFS_CHA_CV) ||
             (a == `TEFB_OFS_MCHA_CV);
  endfunction

  // Trigger edge selection
  tefb_trig_edge u_trig
  (
    .pclk    (pclk),
    .presetn (presetn),
    .trig_in (events.trig_in),
    .pause   (cfg_q[`TEFB_CFG_PAUSE]),
    .pol_low (cfg_q[`TEFB_CFG_TRGPOL]),
    .trig_ev (trig_ev)
  );

  // Bus phase decode
  assign acc    = psel && penable && !pready;
  assign bad    = !mapped(paddr) || (pwrite && pstrb != 4'hF);
  assign wr_ok  = acc && pwrite && !bad;
  assign rd_acc = acc && !pwrite && !bad;

  // Per-channel mode gating
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      assign cap_ev[g] = events.chan_capture[g] && cfg_q[`TEFB_CFG_INMODE + g];
      assign cmp_ev[g] = events.chan_compare[g] && !cfg_q[`TEFB_CFG_INMODE + g];
      // Capture/compare flag set
      assign set_v[`TEFB_BIT_CH0 + g] = cap_ev[g] || cmp_ev[g];
      // Overcapture while flag still set
      assign set_v[`TEFB_BIT_OF0 + g] = cap_ev[g] && flags_q[`TEFB_BIT_CH0 + g];
    end
  endgenerate

  assign m_cap = events.mchan_capture && cfg_q[`TEFB_CFG_MINMODE];

  // Remaining hardware set terms, one driver per bit slice
  assign set_v[`TEFB_BIT_UPD]  = events.update;
  assign set_v[`TEFB_BIT_CMT]  = events.commutation;
  assign set_v[`TEFB_BIT_TRG]  = trig_ev;
  assign set_v[`TEFB_BIT_BRK]  = events.brk_level;
  assign set_v[8]              = 1'b0;
  assign set_v[19:13]          = 7'h00;
  assign set_v[`TEFB_BIT_MCH0] = m_cap || (events.mchan_compare && !cfg_q[`TEFB_CFG_MINMODE]);
  assign set_v[31:21]          = 11'h000;

  // Software and read side-effect clears
  always_comb
  begin
    clr_v = 32'h0000_0000;
    if (wr_ok && paddr == `TEFB_OFS_FLAGS)
      clr_v = ~pwdata & `TEFB_FLAG_MASK;
    if (events.brk_level)
      clr_v[`TEFB_BIT_BRK] = 1'b0;
    if (rd_acc && paddr == `TEFB_OFS_CHA_CV && cfg_q[`TEFB_CFG_INMODE])
      clr_v[`TEFB_BIT_CH0] = 1'b1;
    if (rd_acc && paddr == `TEFB_OFS_MCHA_CV && cfg_q[`TEFB_CFG_MINMODE])
      clr_v[`TEFB_BIT_MCH0] = 1'b1;
  end

  // Set beats clear
  assign flags_d = ((flags_q & ~clr_v) | set_v) & `TEFB_FLAG_MASK;

  // Flag register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      flags_q <= `TEFB_RST_FLAGS;
    else
      flags_q <= flags_d;

  // Mask and config registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_q <= `TEFB_RST_MASK;
      cfg_q  <= `TEFB_RST_CFG;
    end
    else if (wr_ok)
    begin
      if (paddr == `TEFB_OFS_MASK)
        mask_q <= pwdata & `TEFB_FLAG_MASK;
      if (paddr == `TEFB_OFS_CFG)
        cfg_q <= pwdata & 32'h0000_01F3;
    end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc && bad;
      if (rd_acc)
      begin
        case (paddr)
          `TEFB_OFS_FLAGS:   prdata <= flags_q;
          `TEFB_OFS_MASK:    prdata <= mask_q;
          `TEFB_OFS_CFG:     prdata <= cfg_q;
          `TEFB_OFS_CHA_CV:  prdata <= cha_cv;
          `TEFB_OFS_MCHA_CV: prdata <= mcha_cv;
          default:           prdata <= 32'h0000_0000;
        endcase
      end
      else
        prdata <= 32'h0000_0000;
    end

  // Interrupt output
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flags_d & mask_q);

  // Checks
  overcap_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[0] && flags_q[`TEFB_BIT_CH0] |=> flags_q[`TEFB_BIT_OF0])
    else $error("overcapture a not set");
  overcap_d_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[3] && flags_q[4] |=> flags_q[12])
    else $error("overcapture d not set");
  brk_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    events.brk_level |=> flags_q[`TEFB_BIT_BRK])
    else $error("break flag not held");
  trg_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_ev |=> flags_q[`TEFB_BIT_TRG])
    else $error("trigger flag not set");
  cmt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    events.commutation |=> flags_q[`TEFB_BIT_CMT])
    else $error("commutation flag not set");
  ch_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_ev[1] |=> flags_q[2])
    else $error("channel b flag not set");
  cv_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `TEFB_OFS_CHA_CV && cfg_q[`TEFB_CFG_INMODE] && !cap_ev[0]
    |=> !flags_q[`TEFB_BIT_CH0])
    else $error("cv read did not clear");
  mcv_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `TEFB_OFS_MCHA_CV && cfg_q[`TEFB_CFG_MINMODE] && !set_v[20]
    |=> !flags_q[`TEFB_BIT_MCH0])
    else $error("multi cv read did not clear");
  upd_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    events.update |=> flags_q[0])
    else $error("update flag not set");
  wr_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `TEFB_OFS_FLAGS && pwdata[0] && flags_q[0] |=> flags_q[0])
    else $error("write one changed flag");
  mch_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    m_cap |=> flags_q[`TEFB_BIT_MCH0])
    else $error("multi flag not set");

  // Overcapture on channels b and c
  overcap_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[1] && flags_q[2] |=> flags_q[10])
    else $error("overcapture b not set");
  // Channel c overcapture
  overcap_c_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[2] && flags_q[3] |=> flags_q[11])
    else $error("overcapture c not set");
  // Overcapture stays quiet without a second capture
  of_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_q[`TEFB_BIT_OF0] && !set_v[`TEFB_BIT_OF0] |=> !flags_q[`TEFB_BIT_OF0])
    else $error("overcapture a set spuriously");
  // Overcapture held until software clears
  of_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[9] && !(wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[9]) |=> flags_q[9])
    else $error("overcapture a lost");

  // Channel a capture sets its flag
  ch_a_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[0] |=> flags_q[`TEFB_BIT_CH0])
    else $error("channel a capture lost");
  // Channel a compare sets its flag
  ch_a_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_ev[0] |=> flags_q[`TEFB_BIT_CH0])
    else $error("channel a compare lost");
  // Channel b capture
  ch_b_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[1] |=> flags_q[2])
    else $error("channel b capture lost");
  // Channel c capture
  ch_c_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[2] |=> flags_q[3])
    else $error("channel c capture lost");
  // Channel d capture
  ch_d_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev[3] |=> flags_q[4])
    else $error("channel d capture lost");
  // Channel c compare
  ch_c_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_ev[2] |=> flags_q[3])
    else $error("channel c compare lost");
  // Channel d compare
  ch_d_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_ev[3] |=> flags_q[4])
    else $error("channel d compare lost");
  // Read side effect only in input mode
  cv_out_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `TEFB_OFS_CHA_CV && !cfg_q[`TEFB_CFG_INMODE] && flags_q[1]
    |=> flags_q[1])
    else $error("cv read cleared in output mode");

  // Reserved positions never hold a one
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_q & ~`TEFB_FLAG_MASK) == 32'h0000_0000)
    else $error("reserved flag bit set");
  // Write zero clears the update flag
  wr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[0] && !events.update |=> !flags_q[0])
    else $error("write zero kept update flag");
  // Write zero clears the commutation flag
  wr_zero_cmt_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[5] && !events.commutation
    |=> !flags_q[5])
    else $error("write zero kept commutation flag");
  // Set beats a write clear
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[0] && events.update |=> flags_q[0])
    else $error("clear beat update set");
  // Set beats a read side-effect clear
  cv_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `TEFB_OFS_CHA_CV && cap_ev[0] |=> flags_q[`TEFB_BIT_CH0])
    else $error("read clear beat capture");

  // Break flag clears once input inactive
  brk_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !events.brk_level && wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[7] |=> !flags_q[7])
    else $error("break flag not cleared");
  // Trigger flag sticky
  trg_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[6] && !(wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[6]) |=> flags_q[6])
    else $error("trigger flag lost");
  // Commutation flag sticky
  cmt_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[5] && !(wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[5]) |=> flags_q[5])
    else $error("commutation flag lost");
  // Update flag sticky
  upd_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[0] && !(wr_ok && paddr == `TEFB_OFS_FLAGS && !pwdata[0]) |=> flags_q[0])
    else $error("update flag lost");
  // Multi chan compare in output mode
  mch_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    events.mchan_compare && !cfg_q[`TEFB_CFG_MINMODE] |=> flags_q[`TEFB_BIT_MCH0])
    else $error("multi compare lost");
  // Multi chan flag stays zero without an event
  mch_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_q[`TEFB_BIT_MCH0] && !set_v[`TEFB_BIT_MCH0] |=> !flags_q[`TEFB_BIT_MCH0])
    else $error("multi flag set spuriously");

  // Interrupt follows unmasked flags
  irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(flags_d & mask_q) |=> irq)
    else $error("interrupt not raised");
  // Interrupt drops with no unmasked flag
  irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(flags_d & mask_q)) |=> !irq)
    else $error("interrupt not dropped");
  // Ready is a one-cycle pulse
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // Error only with ready
  slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  // Partial writes are refused
  strb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && pstrb != 4'hF |=> pslverr)
    else $error("partial write not refused");
  // Read data is zero outside the answer
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
endmodule

//--- rtl/tefb_trig_edge.sv
/*
  Trigger edge detector: active edge, or both edges in pause mode.
  Assumes trigger level synchronous to pclk.
*/
`timescale 1ns/100ps
module tefb_trig_edge
(
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Async reset, low
  input  wire logic trig_in,  // Trigger level
  input  wire logic pause,    // Pause mode, both edges
  input  wire logic pol_low,  // Active edge is falling
  output logic      trig_ev   // One-cycle trigger event
);
  logic trig_q;  // Previous trigger level

  // Remember last level
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trig_q <= 1'b0;
    else
      trig_q <= trig_in;

  // Edge select
  always_comb
  begin
    if (pause)
      trig_ev = trig_q ^ trig_in;
    else if (pol_low)
      trig_ev = trig_q & ~trig_in;
    else
      trig_ev = ~trig_q & trig_in;
  end

  pause_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    pause && ($past(trig_in) != trig_in) |-> trig_ev)
    else $error("pause edge missed");
endmodule

//--- tb/tefb_flag_bank_tb.sv
/*
  Self-checking bench for the timer event flag bank: APB tasks, event pulses.
  Assumes the consts header on the include path and the design files compiled first.
*/
`timescale 1ns/100ps
`include "tefb_consts.svh"
module tefb_flag_bank_tb;
  import tefb_pkg::*;
  logic         pclk;             // Clock, 125 MHz
  logic         presetn;          // Reset, low
  logic         psel;             // APB select
  logic         penable;          // APB enable
  logic         pwrite;           // APB direction
  logic [11:0]  paddr;            // APB address
  logic [31:0]  pwdata;           // APB write data
  logic [3:0]   pstrb;            // APB strobes
  tefb_events_t ev;               // Core events
  logic [31:0]  prdata;           // APB read data
  logic         pready;           // APB ready
  logic         pslverr;          // APB error
  logic         irq;              // Interrupt
  logic [31:0]  rd;               // Last read data
  logic         err;              // Last error
  int           fails;            // Mismatches
  int           samples_checked;  // Comparisons
  localparam logic [11:0] ofs_fl = `TEFB_OFS_FLAGS;  // Flags
  localparam logic [11:0] ofs_mk = `TEFB_OFS_MASK;   // Mask
  localparam logic [11:0] ofs_cf = `TEFB_OFS_CFG;    // Config

  tefb_flag_bank u_tefb_flag_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .events(ev), .cha_cv(32'h1234_5678), .mcha_cv(32'h9ABC_DEF0), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  // Free-running clock
  always #4 pclk = ~pclk;

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16)
      fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full-word write and checked read
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, e);
  endtask

  // One-cycle pulse on the chosen event bits
  task automatic pulse(input tefb_events_t m);
    @(posedge pclk);
    ev <= ev | m;
    @(posedge pclk);
    ev <= ev & ~m;
  endtask

  // Level change on trigger or break input
  task automatic lvl(input logic t, input logic b);
    @(posedge pclk);
    ev.trig_in <= t;
    ev.brk_level <= b;
  endtask

  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (4000) @(posedge pclk);
    fails++;
    print_verdict;
  end

  // Test sequence
  initial
  begin
    tefb_events_t m;
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0; ev = '0;
    fails = 0; samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, refused accesses
    rdc(ofs_fl, `TEFB_RST_FLAGS);
    rdc(ofs_mk, `TEFB_RST_MASK);
    rdc(ofs_cf, `TEFB_RST_CFG);
    rdc(12'h0FC, 32'h0000_0000);
    apb(1'b1, ofs_fl, 32'h0000_0000, 4'h3);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test reset done");
    // Output mode events, write-zero clear
    m = '0; m.update = 1'b1; m.commutation = 1'b1; m.chan_compare = 4'hF;
    m.mchan_compare = 1'b1;
    pulse(m);
    rdc(ofs_fl, 32'h0010_003F);
    wr(ofs_fl, 32'h0010_1EDE);
    rdc(ofs_fl, 32'h0010_001E);
    wr(ofs_fl, 32'h0000_0000);
    rdc(ofs_fl, 32'h0000_0000);
    $display("test output events done");
    // Input mode capture, overcapture, read side effects
    wr(ofs_cf, 32'h0000_01F0);
    m = '0; m.chan_capture = 4'hF; m.mchan_capture = 1'b1;
    pulse(m);
    rdc(ofs_fl, 32'h0010_001E);
    pulse(m);
    rdc(ofs_fl, 32'h0010_1E1E);
    rdc(`TEFB_OFS_CHA_CV, 32'h1234_5678);
    rdc(ofs_fl, 32'h0010_1E1C);
    rdc(`TEFB_OFS_MCHA_CV, 32'h9ABC_DEF0);
    rdc(ofs_fl, 32'h0000_1E1C);
    wr(ofs_fl, 32'h0000_0000);
    $display("test capture done");
    // Trigger edges: rising, pause, falling
    for (int i = 0; i < 3; i++)
    begin
      wr(ofs_cf, i);
      lvl(1'b1, 1'b0);
      rdc(ofs_fl, (i != 2) ? 32'h0000_0040 : 32'h0000_0000);
      wr(ofs_fl, 32'h0000_0000);
      lvl(1'b0, 1'b0);
      rdc(ofs_fl, (i != 0) ? 32'h0000_0040 : 32'h0000_0000);
      wr(ofs_fl, 32'h0000_0000);
    end
    $display("test trigger done");
    // Break flag holds while input active
    lvl(1'b0, 1'b1);
    rdc(ofs_fl, 32'h0000_0080);
    wr(ofs_fl, 32'h0000_0000);
    rdc(ofs_fl, 32'h0000_0080);
    lvl(1'b0, 1'b0);
    wr(ofs_fl, 32'h0000_0000);
    rdc(ofs_fl, 32'h0000_0000);
    $display("test break done");
    // Set and clear in the same cycle
    fork
      wr(ofs_fl, 32'h0000_0000);
      begin
        m = '0; m.update = 1'b1;
        @(posedge pclk);
        pulse(m);
      end
    join
    rdc(ofs_fl, 32'h0000_0001);
    $display("test set wins done");
    // Interrupt raise, mask, clear
    wr(ofs_mk, 32'h0000_0001);
    rdc(ofs_mk, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    m = '0; m.commutation = 1'b1;
    pulse(m);
    wr(ofs_fl, 32'h0010_1EFE);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ofs_mk, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(ofs_fl, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    print_verdict;
  end
endmodule
